/* File: fpmc_erase_timer.sv */
// Erase time counter that holds the core stalled.
`timescale 1ns/1ns
`include "fpmc_regs.svh"
module fpmc_erase_timer #(
   parameter int ERASE_CYCLES = `FPMC_ERASE_CYCLES
) (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_start,
   output logic o_busy,
   output logic o_done
);
   import fpmc_pkg::*;
   logic [17:0] count;
   // Counts the erase time down from the start pulse; done pulses on the last cycle.
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         count <= 18'h0;
         o_busy <= 1'b0;
         o_done <= 1'b0;
      end else if (i_start) begin
         count <= 18'(ERASE_CYCLES - 1);
         o_busy <= 1'b1;
         o_done <= 1'b0;
      end else if (o_busy) begin
         count <= count - 18'h1;
         o_done <= (count == 18'h1);
         o_busy <= (count != 18'h1);
      end else begin
         o_done <= 1'b0;
      end
   end
endmodule // fpmc_erase_timer

/* File: fpmc_flash_control.sv */
// Flash program memory self-programming controller top level.
// How it works
// - Data low returns read bits, software writable.
// - Data high holds six bits, top zero.
// - Address high holds four bits, top zero.
// - Control bit seven reads one, 5-3 zero.
// - Bit six selects calibration area for reads.
// - Bit two permits writes, else blocked.
// - Write bit set-only, hardware clears on completion.
// - Read bit set-only, hardware clears it.
// - Read occurs second cycle; that slot skipped.
// - Read data held until next read/write.
// - Write-protect bits gate self-programmed words.
// - Code protection blocks serial port writes.
// - Four-word aligned blocks, never crossing boundary.
// - First three words buffered, complete instantly.
// - Last word programs four; erases sixteen only at nibble 0011.
// - Two setup cycles after write start.
// - Core halts during erase, clocks run.
// - Erase only at address low nibble 0011.
// - Unlock key port reads all zeros.
// - Calibration select set means no write.
// - Write permit cleared on power-up.
`timescale 1ns/1ns
`include "fpmc_regs.svh"
module fpmc_flash_control #(
   parameter int ERASE_CYCLES = `FPMC_ERASE_CYCLES
) (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [2:0] i_reg_sel,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [1:0] i_write_protect_cfg,
   input wire logic i_code_protect_n,
   input wire logic i_serial_prog_wr,
   input wire fpmc_pkg::fpmc_word_type i_flash_rdata,
   input wire fpmc_pkg::fpmc_word_type i_cal_rdata,
   output logic [7:0] o_reg_rdata,
   output logic o_core_stall,
   output logic o_skip_slot,
   output fpmc_pkg::fpmc_addr_type o_flash_addr,
   output logic o_flash_rd,
   output logic o_cal_rd,
   output logic o_row_erase,
   output logic o_word_prog,
   output fpmc_pkg::fpmc_word_type o_prog_data,
   output logic o_serial_wr_allow
);
   import fpmc_pkg::*;
   // ==================================================
   // Register state
   logic [7:0] data_low;
   logic [5:0] data_high;
   logic [7:0] addr_low;
   logic [3:0] addr_high;
   logic cal_space_select;
   logic write_permit;
   logic write_bit;
   logic read_bit;
   logic [1:0] read_wait;
   fpmc_word_type block_buf [4];
   fpmc_state_type state;
   fpmc_state_type next_state;
   logic [1:0] setup_count;
   logic [2:0] prog_index;
   logic unlocked;
   logic timer_start;
   logic timer_busy;
   logic timer_done;
   logic write_ok;
   logic write_start;
   logic write_ok_held;
   logic [1:0] serial_req_sync;
   logic [1:0] code_prot_sync;

   // Decodes a register write to one select.
   function automatic logic sel_write(input logic wr, input logic [2:0] sel,
                                      input logic [2:0] want);
      sel_write = wr && (sel == want);
   endfunction

   // Decides whether a target word lies outside the protected segment.
   function automatic logic segment_open(input logic [1:0] cfg, input logic [3:0] hi);
      case (cfg)
         2'h3: segment_open = 1'b1;
         2'h2: segment_open = (hi != 4'h0);
         2'h1: segment_open = (hi[3] == 1'b1);
         default: segment_open = 1'b0;
      endcase
   endfunction

   // ==================================================
   // Unlock key sequence
   fpmc_key_unlock u_key (
      .i_mclk(i_mclk),
      .i_srst(i_srst),
      .i_wr_strobe(i_reg_wr),
      .i_key_sel(i_reg_sel == `FPMC_SEL_KEY),
      .i_wdata(i_reg_wdata),
      .i_consume(write_start),
      .o_unlocked(unlocked)
   );

   // A write start counts only with permit, keys, user space and open segment.
   assign write_start = sel_write(i_reg_wr, i_reg_sel, `FPMC_SEL_CONTROL)
                        && i_reg_wdata[`FPMC_CTL_WRITE] && !write_bit && (state == FPMC_IDLE);
   assign write_ok = write_permit && unlocked && !cal_space_select
                     && segment_open(i_write_protect_cfg, addr_high);

   // ==================================================
   // Address registers.
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         addr_low <= `FPMC_BYTE_ZERO;
         addr_high <= 4'h0;
      end else begin
         if (sel_write(i_reg_wr, i_reg_sel, `FPMC_SEL_ADDR_LOW)) begin
            addr_low <= i_reg_wdata;
         end
         if (sel_write(i_reg_wr, i_reg_sel, `FPMC_SEL_ADDR_HIGH)) begin
            addr_high <= i_reg_wdata[3:0];
         end
      end
   end

   // Data registers take software writes and read returns, read wins.
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         data_low <= `FPMC_BYTE_ZERO;
         data_high <= 6'h0;
      end else if (read_wait == 2'h1) begin
         data_low <= cal_space_select ? i_cal_rdata[7:0] : i_flash_rdata[7:0];
         data_high <= cal_space_select ? i_cal_rdata[13:8] : i_flash_rdata[13:8];
      end else begin
         if (sel_write(i_reg_wr, i_reg_sel, `FPMC_SEL_DATA_LOW)) begin
            data_low <= i_reg_wdata;
         end
         if (sel_write(i_reg_wr, i_reg_sel, `FPMC_SEL_DATA_HIGH)) begin
            data_high <= i_reg_wdata[5:0];
         end
      end
   end

   // Control bits: permit and select writable, read and write set-only.
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         cal_space_select <= 1'b0;
         write_permit <= 1'b0;
      end else if (sel_write(i_reg_wr, i_reg_sel, `FPMC_SEL_CONTROL)) begin
         cal_space_select <= i_reg_wdata[`FPMC_CTL_CAL_SEL];
         write_permit <= i_reg_wdata[`FPMC_CTL_PERMIT];
      end
   end

   // Read bit: set by software, counts to the second cycle, then clears.
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         read_bit <= 1'b0;
         read_wait <= 2'h0;
      end else if (sel_write(i_reg_wr, i_reg_sel, `FPMC_SEL_CONTROL)
                   && i_reg_wdata[`FPMC_CTL_READ] && !read_bit) begin
         read_bit <= 1'b1;
         read_wait <= `FPMC_READ_DELAY;
      end else if (read_wait != 2'h0) begin
         read_wait <= read_wait - 2'h1;
         read_bit <= (read_wait != 2'h1);
      end
   end

   // Flash read strobes and the skipped instruction slot.
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_flash_rd <= 1'b0;
         o_cal_rd <= 1'b0;
         o_skip_slot <= 1'b0;
      end else begin
         o_flash_rd <= (read_wait == 2'h2) && !cal_space_select;
         o_cal_rd <= (read_wait == 2'h2) && cal_space_select;
         o_skip_slot <= (read_wait == 2'h2);
      end
   end

   // ==================================================
   // Block buffer: each accepted word lands at its low two address bits.
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         block_buf[0] <= 14'h0;
         block_buf[1] <= 14'h0;
         block_buf[2] <= 14'h0;
         block_buf[3] <= 14'h0;
      end else if (write_start && write_ok) begin
         block_buf[addr_low[1:0]] <= {data_high, data_low};
      end
   end

   // Write sequencer state register.
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         state <= FPMC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Next state: only the last block word goes through program, with erase first only for a row-opening block.
   always_comb begin
      next_state = state;
      case (state)
         FPMC_IDLE: begin
            if (write_start) begin
               next_state = FPMC_SETUP;
            end
         end
         FPMC_SETUP: begin
            if (setup_count == 2'h1) begin
               if (write_ok_held && addr_low[1:0] == `FPMC_BLOCK_LAST) begin
                  next_state = timer_start ? FPMC_ERASE : FPMC_PROGRAM;
               end else begin
                  next_state = FPMC_DONE;
               end
            end
         end
         FPMC_ERASE: begin
            if (timer_done) begin
               next_state = FPMC_PROGRAM;
            end
         end
         FPMC_PROGRAM: begin
            if (prog_index == 3'h3) begin
               next_state = FPMC_DONE;
            end
         end
         FPMC_DONE: next_state = FPMC_IDLE;
         default: next_state = FPMC_IDLE;
      endcase
   end

   // Setup counter, latched permission and the write bit.
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         setup_count <= 2'h0;
         write_ok_held <= 1'b0;
         write_bit <= 1'b0;
      end else if (state == FPMC_IDLE && write_start) begin
         setup_count <= `FPMC_SETUP_CYCLES;
         write_ok_held <= write_ok;
         write_bit <= 1'b1;
      end else begin
         if (setup_count != 2'h0) begin
            setup_count <= setup_count - 2'h1;
         end
         if (state == FPMC_DONE) begin
            write_bit <= 1'b0;
         end
      end
   end

   // Erase and its stall only for a row-opening block; other last words program at once.
   assign timer_start = (state == FPMC_SETUP) && (setup_count == 2'h1)
                        && write_ok_held && (addr_low[3:0] == `FPMC_ROW_ERASE_NIBBLE);
   fpmc_erase_timer #(.ERASE_CYCLES(ERASE_CYCLES)) u_timer (
      .i_mclk(i_mclk),
      .i_srst(i_srst),
      .i_start(timer_start),
      .o_busy(timer_busy),
      .o_done(timer_done)
   );

   // Flash strobes: row erase, then four word programs within the block.
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_row_erase <= 1'b0;
         o_word_prog <= 1'b0;
         o_prog_data <= 14'h0;
         o_flash_addr <= 12'h0;
         prog_index <= 3'h0;
         o_core_stall <= 1'b0;
      end else begin
         o_row_erase <= timer_start && (addr_low[3:0] == `FPMC_ROW_ERASE_NIBBLE);
         o_core_stall <= timer_start || timer_busy;
         if (state == FPMC_PROGRAM) begin
            o_word_prog <= 1'b1;
            o_prog_data <= block_buf[prog_index[1:0]];
            o_flash_addr <= {addr_high, addr_low[7:2], prog_index[1:0]};
            prog_index <= prog_index + 3'h1;
         end else begin
            o_word_prog <= 1'b0;
            prog_index <= 3'h0;
            o_flash_addr <= {addr_high, addr_low};
         end
      end
   end

   // Serial port writes pass only without code protection; both pins are synchronised first.
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         serial_req_sync <= 2'h0;
         code_prot_sync <= 2'h0;
         o_serial_wr_allow <= 1'b0;
      end else begin
         serial_req_sync <= {serial_req_sync[0], i_serial_prog_wr};
         code_prot_sync <= {code_prot_sync[0], i_code_protect_n};
         o_serial_wr_allow <= serial_req_sync[1] && code_prot_sync[1];
      end
   end

   // ==================================================
   // Register read mux, registered.
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_reg_rdata <= `FPMC_BYTE_ZERO;
      end else if (i_reg_rd) begin
         case (i_reg_sel)
            `FPMC_SEL_DATA_LOW: o_reg_rdata <= data_low;
            `FPMC_SEL_DATA_HIGH: o_reg_rdata <= {2'h0, data_high};
            `FPMC_SEL_ADDR_LOW: o_reg_rdata <= addr_low;
            `FPMC_SEL_ADDR_HIGH: o_reg_rdata <= {4'h0, addr_high};
            `FPMC_SEL_CONTROL: o_reg_rdata <= {1'b1, cal_space_select, 3'h0,
                                              write_permit, write_bit, read_bit};
            `FPMC_SEL_KEY: o_reg_rdata <= `FPMC_BYTE_ZERO;
            default: o_reg_rdata <= `FPMC_BYTE_ZERO;
         endcase
      end
   end

   // ==================================================
   // Assertions.
   a_read_skip_slot: assert property (@(posedge i_mclk) disable iff (i_srst)
      $rose(read_bit) |-> ##1 o_skip_slot)
      else $error("Read slot not taken two cycles after start.");
   a_read_bit_clear: assert property (@(posedge i_mclk) disable iff (i_srst)
      $rose(read_bit) |-> read_bit ##1 read_bit ##1 !read_bit)
      else $error("Read bit did not self clear.");
   a_data_hold: assert property (@(posedge i_mclk) disable iff (i_srst)
      (read_wait != 2'h1 && !i_reg_wr) |=> $stable(data_low) && $stable(data_high))
      else $error("Data registers changed without cause.");
   a_no_write_blocked: assert property (@(posedge i_mclk) disable iff (i_srst)
      (write_start && !write_permit) |-> ##2 (next_state == FPMC_DONE))
      else $error("Write ran without permit.");
   a_cal_no_erase: assert property (@(posedge i_mclk) disable iff (i_srst)
      (write_start && cal_space_select) |-> ##2 (next_state == FPMC_DONE))
      else $error("Write ran with calibration select.");
   a_stall_on_erase: assert property (@(posedge i_mclk) disable iff (i_srst)
      timer_start |=> o_core_stall)
      else $error("Core not stalled at erase.");
   a_write_bit_hold: assert property (@(posedge i_mclk) disable iff (i_srst)
      (write_bit && state != FPMC_DONE) |=> write_bit)
      else $error("Write bit cleared early.");
   a_buffer_fast: assert property (@(posedge i_mclk) disable iff (i_srst)
      (write_start && addr_low[1:0] != `FPMC_BLOCK_LAST) |-> ##4 !write_bit)
      else $error("Buffered word did not complete quickly.");
   a_permit_reset: assert property (@(posedge i_mclk)
      ($past(i_srst) && !i_srst) |-> !write_permit)
      else $error("Permit set after reset.");
endmodule // fpmc_flash_control

/* File: fpmc_flash_model.sv */
// Behavioural model of the flash program memory array behind the controller.
`timescale 1ns/1ns
module fpmc_flash_model #(
   parameter logic [13:0] CAL_WORD = 14'h1c3d
) (
   input wire logic i_mclk,
   input wire fpmc_pkg::fpmc_addr_type i_addr,
   input wire logic i_rd,
   input wire logic i_cal_rd,
   input wire logic i_erase,
   input wire logic i_prog,
   input wire fpmc_pkg::fpmc_word_type i_pdata,
   output fpmc_pkg::fpmc_word_type o_rdata,
   output fpmc_pkg::fpmc_word_type o_cal_rdata,
   output logic [7:0] o_erase_cnt
);
   import fpmc_pkg::*;
   fpmc_word_type mem [0:4095];
   fpmc_word_type junk;
   // Known start pattern that the bench can predict from the address.
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 14'(i) ^ 14'h2a5a;
      end
      junk = 14'h0000;
      o_erase_cnt = 8'h00;
   end
   // Read data stands only while a strobe is high; otherwise the lines toggle each cycle.
   always @(posedge i_mclk) begin
      junk <= ~junk;
   end
   assign o_rdata = i_rd ? mem[i_addr] : junk;
   assign o_cal_rdata = i_cal_rd ? CAL_WORD : ~junk;
   // Row erase clears sixteen words, then each program cycle stores one word.
   always @(posedge i_mclk) begin
      if (i_erase) begin
         for (int k = 0; k < 16; k++) begin
            mem[{i_addr[11:4], 4'(k)}] = 14'h3fff;
         end
         o_erase_cnt <= o_erase_cnt + 8'h01;
      end
      if (i_prog) begin
         mem[i_addr] = i_pdata;
      end
   end
endmodule // fpmc_flash_model

/* File: fpmc_key_unlock.sv */
// Unlock key detector for the write start sequence.
`timescale 1ns/1ns
`include "fpmc_regs.svh"
module fpmc_key_unlock (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_wr_strobe,
   input wire logic i_key_sel,
   input wire logic [7:0] i_wdata,
   input wire logic i_consume,
   output logic o_unlocked
);
   import fpmc_pkg::*;
   logic first_seen;
   // Tracks 55h then AAh as the very last two register writes; any other write breaks it.
   always_ff @(posedge i_mclk) begin
      if (i_srst || i_consume) begin
         first_seen <= 1'b0;
         o_unlocked <= 1'b0;
      end else if (i_wr_strobe) begin
         first_seen <= i_key_sel && (i_wdata == `FPMC_KEY_FIRST);
         o_unlocked <= i_key_sel && first_seen && (i_wdata == `FPMC_KEY_SECOND);
      end
   end
   // The armed flag only rises right after the second key byte, when the first key byte came just before it.
   a_key_order: assert property (@(posedge i_mclk) disable iff (i_srst)
      $rose(o_unlocked) |-> $past(first_seen))
      else $error("Unlock armed without first key byte.");
endmodule // fpmc_key_unlock

/* File: fpmc_pkg.sv */
// Types shared by the flash program memory controller.
package fpmc_pkg;
   // Write sequencer states.
   typedef enum logic [2:0] {
      FPMC_IDLE = 3'b000,
      FPMC_SETUP = 3'b001,
      FPMC_ERASE = 3'b010,
      FPMC_PROGRAM = 3'b011,
      FPMC_DONE = 3'b100
   } fpmc_state_type;
   typedef logic [13:0] fpmc_word_type;
   typedef logic [11:0] fpmc_addr_type;
endpackage

/* File: fpmc_regs.svh */
// Register offsets, field positions, reset values and timing counts of the flash controller.
`ifndef FPMC_REGS_SVH
`define FPMC_REGS_SVH
// ==================================================
// Register selects on the special function register port
`define FPMC_SEL_DATA_LOW 3'h0
`define FPMC_SEL_DATA_HIGH 3'h1
`define FPMC_SEL_ADDR_LOW 3'h2
`define FPMC_SEL_ADDR_HIGH 3'h3
`define FPMC_SEL_CONTROL 3'h4
`define FPMC_SEL_KEY 3'h5
// ==================================================
// Control register fields
`define FPMC_CTL_FIXED_ONE 7
`define FPMC_CTL_CAL_SEL 6
`define FPMC_CTL_PERMIT 2
`define FPMC_CTL_WRITE 1
`define FPMC_CTL_READ 0
`define FPMC_BYTE_ZERO 8'h00
`define FPMC_DATA_HIGH_MASK 8'h3f
`define FPMC_ADDR_HIGH_MASK 8'h0f
// ==================================================
// Unlock key bytes
`define FPMC_KEY_FIRST 8'h55
`define FPMC_KEY_SECOND 8'haa
// ==================================================
// Block layout: low address bits that close a block and open a row
`define FPMC_BLOCK_LAST 2'h3
`define FPMC_ROW_ERASE_NIBBLE 4'h3
// ==================================================
// Timing: erase time in microseconds and the clock rate in MHz
`define FPMC_ERASE_US 4000
`define FPMC_CLK_MHZ 50
`define FPMC_ERASE_CYCLES (`FPMC_ERASE_US * `FPMC_CLK_MHZ)
`define FPMC_READ_DELAY 2'h2
`define FPMC_SETUP_CYCLES 2'h2
`endif

/* File: tb.sv */
// Self-checking bench for the flash program memory controller.
`timescale 1ns/1ns
`include "fpmc_regs.svh"
module tb;
   import fpmc_pkg::*;
   logic i_mclk = 1'b0, i_srst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
   logic [2:0] i_reg_sel = 3'h0;
   logic [7:0] i_reg_wdata = 8'h00, o_reg_rdata, erase_cnt;
   logic [1:0] wp = 2'h3;
   logic cp_n = 1'b1, ser_wr = 1'b0;
   fpmc_word_type flash_rdata, cal_rdata, prog_data;
   fpmc_addr_type flash_addr;
   logic core_stall, skip_slot, flash_rd, cal_rd, row_erase, word_prog, ser_allow;
   logic [15:0] stall_cyc = 16'h0000, skip_cnt = 16'h0000;
   int error_cnt = 0, checked = 0;
   // =====================================
   // Design and array model
   fpmc_flash_control #(.ERASE_CYCLES(20)) dut_u (.i_mclk(i_mclk), .i_srst(i_srst),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_sel(i_reg_sel),
      .i_reg_wdata(i_reg_wdata), .i_write_protect_cfg(wp), .i_code_protect_n(cp_n),
      .i_serial_prog_wr(ser_wr), .i_flash_rdata(flash_rdata), .i_cal_rdata(cal_rdata),
      .o_reg_rdata(o_reg_rdata), .o_core_stall(core_stall), .o_skip_slot(skip_slot),
      .o_flash_addr(flash_addr), .o_flash_rd(flash_rd), .o_cal_rd(cal_rd),
      .o_row_erase(row_erase), .o_word_prog(word_prog), .o_prog_data(prog_data),
      .o_serial_wr_allow(ser_allow));
   fpmc_flash_model flash_u (.i_mclk(i_mclk), .i_addr(flash_addr), .i_rd(flash_rd),
      .i_cal_rd(cal_rd), .i_erase(row_erase), .i_prog(word_prog), .i_pdata(prog_data),
      .o_rdata(flash_rdata), .o_cal_rdata(cal_rdata), .o_erase_cnt(erase_cnt));
   // Clock at 50 MHz.
   initial begin
      forever #10 i_mclk = ~i_mclk;
   end
   // Stall and skipped-slot cycles are counted for later comparison.
   always @(posedge i_mclk) begin
      if (core_stall === 1'b1) stall_cyc <= stall_cyc + 16'h1;
      if (skip_slot === 1'b1) skip_cnt <= skip_cnt + 16'h1;
   end
   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic summarize();
      if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic reg_wr(input logic [2:0] s, input logic [7:0] d);
      @(posedge i_mclk); #1;
      i_reg_wr = 1'b1; i_reg_sel = s; i_reg_wdata = d;
      @(posedge i_mclk); #1;
      i_reg_wr = 1'b0;
   endtask
   task automatic reg_rd(input logic [2:0] s, output logic [7:0] d);
      @(posedge i_mclk); #1;
      i_reg_rd = 1'b1; i_reg_sel = s;
      @(posedge i_mclk); #1;
      i_reg_rd = 1'b0;
      d = o_reg_rdata;
   endtask
   // Reads one word through the data registers; cal picks the calibration area.
   task automatic rd_word(input logic [11:0] a, input logic cal, output logic [13:0] w);
      logic [7:0] lo, hi;
      reg_wr(`FPMC_SEL_ADDR_HIGH, {4'h0, a[11:8]});
      reg_wr(`FPMC_SEL_ADDR_LOW, a[7:0]);
      reg_wr(`FPMC_SEL_CONTROL, {1'b0, cal, 6'h01});
      repeat (4) @(posedge i_mclk);
      reg_rd(`FPMC_SEL_DATA_LOW, lo);
      reg_rd(`FPMC_SEL_DATA_HIGH, hi);
      w = {hi[5:0], lo};
   endtask
   // Full word write sequence; ctl is the start value, keys off skips the unlock pair.
   task automatic wr_word(input logic [11:0] a, input logic [13:0] w, input logic [7:0] ctl,
                          input logic keys);
      logic [7:0] c;
      reg_wr(`FPMC_SEL_CONTROL, ctl & 8'hfd);
      reg_wr(`FPMC_SEL_ADDR_HIGH, {4'h0, a[11:8]});
      reg_wr(`FPMC_SEL_ADDR_LOW, a[7:0]);
      reg_wr(`FPMC_SEL_DATA_LOW, w[7:0]);
      reg_wr(`FPMC_SEL_DATA_HIGH, {2'h0, w[13:8]});
      if (keys) reg_wr(`FPMC_SEL_KEY, `FPMC_KEY_FIRST);
      if (keys) reg_wr(`FPMC_SEL_KEY, `FPMC_KEY_SECOND);
      reg_wr(`FPMC_SEL_CONTROL, ctl);
      repeat (2) @(posedge i_mclk);
      c = 8'h02;
      for (int i = 0; i < 200 && c[1] !== 1'b0; i++) reg_rd(`FPMC_SEL_CONTROL, c);
      chk("write bit cleared", {15'h0, c[1]}, 16'h0);
   endtask
   // =====================================
   // Scenarios
   task automatic t_regs();
      logic [7:0] d;
      reg_rd(`FPMC_SEL_CONTROL, d);
      chk("control after reset", d, 16'h80);
      reg_rd(`FPMC_SEL_KEY, d);
      chk("key port", d, 16'h00);
      reg_wr(`FPMC_SEL_DATA_LOW, 8'ha5);
      reg_rd(`FPMC_SEL_DATA_LOW, d);
      chk("data low", d, 16'ha5);
      reg_wr(`FPMC_SEL_DATA_HIGH, 8'hff);
      reg_rd(`FPMC_SEL_DATA_HIGH, d);
      chk("data high", d, 16'h3f);
      reg_wr(`FPMC_SEL_ADDR_HIGH, 8'hff);
      reg_rd(`FPMC_SEL_ADDR_HIGH, d);
      chk("addr high", d, 16'h0f);
      reg_wr(`FPMC_SEL_CONTROL, 8'h78);
      reg_rd(`FPMC_SEL_CONTROL, d);
      chk("control fixed bits", d, 16'hc0);
   endtask
   task automatic t_read();
      logic [13:0] w;
      logic [15:0] s0;
      logic [7:0] lo, hi;
      s0 = skip_cnt;
      rd_word(12'h123, 1'b0, w);
      chk("user read", w, 16'(14'h123 ^ 14'h2a5a));
      chk("skipped slots", skip_cnt - s0, 16'h1);
      rd_word(12'h124, 1'b1, w);
      chk("cal read", w, 16'h1c3d);
      repeat (6) @(posedge i_mclk);
      reg_rd(`FPMC_SEL_DATA_LOW, lo);
      reg_rd(`FPMC_SEL_DATA_HIGH, hi);
      chk("read data held", {2'h0, hi[5:0], lo}, 16'h1c3d);
   endtask
   task automatic t_block(input logic [11:0] base, input logic erase);
      logic [13:0] w;
      logic [15:0] s0;
      logic [7:0] e0;
      s0 = stall_cyc;
      e0 = erase_cnt;
      for (int k = 0; k < 4; k++) wr_word(base + 12'(k), 14'h0100 + 14'(k), 8'h06, 1'b1);
      chk("erase count", erase_cnt - e0, {15'h0, erase});
      chk("stall length ok", (stall_cyc - s0 >= 16'd20) == erase, 16'h1);
      for (int k = 0; k < 4; k++) begin
         rd_word(base + 12'(k), 1'b0, w);
         chk("programmed word", w, 16'h0100 + 16'(k));
      end
      rd_word(base + 12'h4, 1'b0, w);
      chk("row neighbour", w, 16'h3fff);
      rd_word(base - 12'h4, 1'b0, w);
      chk("earlier word", w, erase ? 16'(14'(base - 12'h4) ^ 14'h2a5a) : 16'h0100);
   endtask
   // Rewrites one word of a block; the other three are read back and passed through.
   task automatic t_partial();
      logic [13:0] w;
      for (int k = 0; k < 4; k++) begin
         rd_word(12'h080 + 12'(k), 1'b0, w);
         wr_word(12'h080 + 12'(k), (k == 2) ? 14'h0555 : w, 8'h06, 1'b1);
      end
      rd_word(12'h081, 1'b0, w);
      chk("kept word", w, 16'(14'h081 ^ 14'h2a5a));
      rd_word(12'h082, 1'b0, w);
      chk("changed word", w, 16'h0555);
   endtask
   task automatic t_refuse(input logic [7:0] ctl, input logic keys, input logic [1:0] prot);
      logic [13:0] w;
      logic [7:0] e0;
      e0 = erase_cnt;
      wp = prot;
      for (int k = 0; k < 4; k++) wr_word(12'h050 + 12'(k), 14'h0777, ctl, keys);
      wp = 2'h3;
      chk("no erase", erase_cnt - e0, 16'h0);
      rd_word(12'h053, 1'b0, w);
      chk("word unchanged", w, 16'(14'h053 ^ 14'h2a5a));
   endtask
   task automatic t_serial();
      ser_wr = 1'b1;
      repeat (3) @(posedge i_mclk);
      #1;
      chk("serial allowed", {15'h0, ser_allow}, 16'h1);
      cp_n = 1'b0;
      repeat (3) @(posedge i_mclk);
      #1;
      chk("serial blocked", {15'h0, ser_allow}, 16'h0);
      ser_wr = 1'b0;
      cp_n = 1'b1;
   endtask
   // Main sequence after a two-cycle reset.
   initial begin
      repeat (2) @(posedge i_mclk);
      #1 i_srst = 1'b0;
      t_regs();
      t_read();
      t_block(12'h040, 1'b1);
      t_block(12'h044, 1'b0);
      t_partial();
      t_refuse(8'h06, 1'b0, 2'h3);
      t_refuse(8'h02, 1'b1, 2'h3);
      t_refuse(8'h46, 1'b1, 2'h3);
      t_refuse(8'h06, 1'b1, 2'h0);
      t_serial();
      summarize();
   end
   // Watchdog that ends a hung run.
   initial begin
      repeat (60000) @(posedge i_mclk);
      error_cnt++;
      summarize();
   end
endmodule // tb
